// ---- rtl/radio_mode_controller.sv ----
`timescale 1ns/100ps
`include "radio_mode_regs.svh"

// How it works
// - Power-up set leaves power down to idle
// - Receive needs activate; clearing returns idle, transmit first finishes its packet
// - Transmitter, activate high, FIFO empty: clocks-on idle
// - Upload in clocks-on idle starts synthesizer, settles
// - Idle states keep settings and register port
// - Power-up, receive select, activate give receive
// - Accept matching valid packets, drop when full
// - Stay receiving; protocol may switch modes itself
// - Power flag needs strong signal for 40us
// - Transmit needs payload and activate over 10us
// - After packet: idle, next packet, or clocks-on
// - Automatic protocol caps transmit stay at 4ms
// - Activate held drains FIFO while refilled
// - Clocks-on idle transmits when select returns high
// - Short activate pulse sends exactly one packet
// - Wake to low-current idle within 150us
// - Idle-to-active and turnarounds within 130us, transmit held while select low
// - Air rate follows the rate select setting; code 3 keeps it
// - Power-up, activate low, no transmit: idle
// - Power-up clear gives power down, settings kept
// - Reset ends in power down
module radio_mode_controller
	import radio_mode_pkg::*;
#(
	parameter int TX_MAX_CYCLES = `TX_MAX_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic power_up_bit,
	input wire logic primary_receive_select,
	input wire logic activate,
	input wire logic select_n,
	input wire logic tx_fifo_empty,
	input wire logic tx_upload,
	input wire logic auto_protocol_en,
	input wire logic ack_send_req,
	input wire logic tx_packet_done,
	input wire logic rx_packet_end,
	input wire logic rx_addr_match,
	input wire logic rx_crc_ok,
	input wire logic rx_fifo_full,
	input wire logic rx_signal_strong,
	input wire logic [1:0] air_rate_select,
	output mode_e mode,
	output logic osc_on,
	output logic clock_buffers_on,
	output logic synth_on,
	output logic rx_chain_on,
	output logic tx_chain_on,
	output logic tx_start,
	output logic tx_abort,
	output logic rx_store,
	output logic rx_drop,
	output logic received_power_flag,
	output rate_t air_rate,
	output logic regs_accessible
);

	// ----------------------------------------
	// Constants and declarations
	// ----------------------------------------
	localparam int DWELL_W = $clog2(TX_MAX_CYCLES + 1);
	localparam logic [11:0] WAKE_LOAD = 12'(`WAKE_CYCLES - 1);
	localparam logic [11:0] SETTLE_LOAD = 12'(`SETTLE_CYCLES - 1);
	localparam logic [7:0] ACT_LAST = 8'(`ACT_PULSE_CYCLES - 1);
	localparam logic [DWELL_W-1:0] DWELL_LOAD = DWELL_W'(TX_MAX_CYCLES - 1);
	mode_e next_mode;
	logic act_armed, next_act_armed, ack_turn, next_ack_turn, act_qualified;
	logic [7:0] act_count, next_act_count;
	logic timer_load, timer_expired, dwell_load, dwell_expired, tx_timeout;
	logic [11:0] timer_value;
	logic tx_end, next_tx_start, next_tx_abort, next_rx_store, next_rx_drop;
	logic rx_good;
	rate_t next_air_rate;

	// ----------------------------------------
	// Timers and power detector
	// ----------------------------------------
	mode_timer #(.WIDTH(12)) settle_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.load(timer_load),
		.value(timer_value),
		.expired(timer_expired)
	);
	mode_timer #(.WIDTH(DWELL_W)) dwell_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.load(dwell_load),
		.value(DWELL_LOAD),
		.expired(dwell_expired)
	);
	rpd_filter #(.HOLD(`RPD_CYCLES), .WIDTH(10)) power_detect (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.enable(mode == RX),
		.raw(rx_signal_strong),
		.flag(received_power_flag)
	);

	// ----------------------------------------
	// Mode sequencer
	// ----------------------------------------
	always_comb begin
		next_mode = mode;
		next_ack_turn = ack_turn;
		timer_load = 1'b0;
		timer_value = SETTLE_LOAD;
		dwell_load = 1'b0;
		next_tx_start = 1'b0;
		next_tx_abort = 1'b0;
		// Pulse held long enough, measured by the activate counter
		act_qualified = activate && (act_count == ACT_LAST);
		next_act_count = activate ?
			((act_count == ACT_LAST) ? act_count : act_count + 1'b1) : 8'h00;
		next_act_armed = act_armed || act_qualified;
		tx_timeout = auto_protocol_en && dwell_expired;
		tx_end = tx_packet_done || tx_timeout;
		case (mode)
			POWER_DOWN: begin
				if (power_up_bit) begin
					next_mode = WAKE;
					timer_load = 1'b1;
					timer_value = WAKE_LOAD;
				end
			end
			WAKE: begin
				if (timer_expired) begin
					next_mode = IDLE_LOW;
				end
			end
			IDLE_LOW: begin
				if (activate && primary_receive_select) begin
					next_mode = SETTLE_RX;
					timer_load = 1'b1;
				end else if ((act_armed || act_qualified) &&
					!primary_receive_select && !tx_fifo_empty) begin
					next_mode = SETTLE_TX;
					timer_load = 1'b1;
				end
			end
			SETTLE_RX: begin
				if (!activate) begin
					next_mode = IDLE_LOW;
					next_ack_turn = 1'b0;
				end else if (timer_expired) begin
					next_mode = RX;
				end
			end
			SETTLE_TX: begin
				// Hold off while the controller still has select low
				if (timer_expired && select_n) begin
					next_mode = TX;
					dwell_load = 1'b1;
					next_tx_start = 1'b1;
				end
			end
			RX: begin
				if (!activate) begin
					next_mode = IDLE_LOW;
				end else if (auto_protocol_en && ack_send_req) begin
					next_mode = SETTLE_TX;
					next_ack_turn = 1'b1;
					timer_load = 1'b1;
				end else if (!primary_receive_select && !tx_fifo_empty) begin
					next_mode = SETTLE_TX;
					timer_load = 1'b1;
				end
			end
			TX: begin
				if (tx_end) begin
					next_tx_abort = tx_timeout && !tx_packet_done;
					if (ack_turn) begin
						next_mode = SETTLE_RX;
						next_ack_turn = 1'b0;
						timer_load = 1'b1;
					end else if (!activate) begin
						next_mode = IDLE_LOW;
					end else if (tx_fifo_empty) begin
						next_mode = IDLE_CLK;
					end else if (tx_timeout) begin
						// Break the stay, resettle, then carry on draining
						next_mode = SETTLE_TX;
						timer_load = 1'b1;
					end else begin
						next_tx_start = 1'b1;
					end
				end
			end
			IDLE_CLK: begin
				if (!activate) begin
					next_mode = IDLE_LOW;
				end else if (tx_upload) begin
					next_mode = SETTLE_TX;
					timer_load = 1'b1;
				end
			end
			default: next_mode = POWER_DOWN;
		endcase
		if (!power_up_bit) begin
			next_mode = POWER_DOWN;
			next_ack_turn = 1'b0;
			next_tx_start = 1'b0;
		end
		if (next_mode != IDLE_LOW) begin
			next_act_armed = 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode <= POWER_DOWN;
			ack_turn <= 1'b0;
			act_armed <= 1'b0;
			act_count <= 8'h00;
			tx_start <= 1'b0;
			tx_abort <= 1'b0;
		end else begin
			mode <= next_mode;
			ack_turn <= next_ack_turn;
			act_armed <= next_act_armed;
			act_count <= next_act_count;
			tx_start <= next_tx_start;
			tx_abort <= next_tx_abort;
		end
	end

	// ----------------------------------------
	// Outputs per mode, receive verdicts, air rate
	// ----------------------------------------
	always_comb begin
		rx_good = rx_packet_end && rx_addr_match && rx_crc_ok && (mode == RX);
		next_rx_store = rx_good && !rx_fifo_full;
		next_rx_drop = rx_good && rx_fifo_full;
		case (air_rate_select)
			`RATE_SEL_250K: next_air_rate = 3'h1 << `RATE_BIT_250K;
			`RATE_SEL_1M: next_air_rate = 3'h1 << `RATE_BIT_1M;
			`RATE_SEL_2M: next_air_rate = 3'h1 << `RATE_BIT_2M;
			default: next_air_rate = air_rate;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			osc_on <= 1'b0;
			clock_buffers_on <= 1'b0;
			synth_on <= 1'b0;
			rx_chain_on <= 1'b0;
			tx_chain_on <= 1'b0;
			rx_store <= 1'b0;
			rx_drop <= 1'b0;
			air_rate <= `RATE_RESET;
			regs_accessible <= 1'b0;
		end else begin
			osc_on <= (next_mode != POWER_DOWN);
			clock_buffers_on <= !(next_mode inside {POWER_DOWN, WAKE,
				IDLE_LOW});
			synth_on <= next_mode inside {SETTLE_RX, SETTLE_TX, RX, TX};
			rx_chain_on <= (next_mode == RX);
			tx_chain_on <= (next_mode == TX);
			rx_store <= next_rx_store;
			rx_drop <= next_rx_drop;
			// Settings never cleared by a mode change
			air_rate <= next_air_rate;
			regs_accessible <= 1'b1;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	localparam int WAKE_MAX = `WAKE_CYCLES;
	localparam int SETTLE_MAX = `SETTLE_CYCLES;
	logic [11:0] wake_cnt, settle_cnt;
	logic [DWELL_W-1:0] tx_cnt;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wake_cnt <= 12'h000;
			settle_cnt <= 12'h000;
			tx_cnt <= '0;
		end else begin
			wake_cnt <= (mode == WAKE) ? wake_cnt + 1'b1 : 12'h000;
			settle_cnt <= (mode == SETTLE_RX) ? settle_cnt + 1'b1 : 12'h000;
			tx_cnt <= (mode == TX) ? tx_cnt + 1'b1 : '0;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_reset_power_down: assert property (disable iff (1'b0)
		sys_rst |=> mode == POWER_DOWN)
		else $error("reset did not end in power down");
	a_clear_power_down: assert property (
		!power_up_bit |=> mode == POWER_DOWN && !synth_on)
		else $error("power-up clear did not reach power down");
	a_wake_bound: assert property (
		mode == WAKE |-> int'(wake_cnt) < WAKE_MAX)
		else $error("wake took too long");
	a_settle_bound: assert property (
		mode == SETTLE_RX |-> int'(settle_cnt) < SETTLE_MAX)
		else $error("receive settling took too long");
	a_dwell_cap: assert property (
		auto_protocol_en && mode == TX |-> int'(tx_cnt) <= TX_MAX_CYCLES)
		else $error("transmit stay exceeded the cap");
	a_activate_drop: assert property (
		mode == RX && !activate && power_up_bit |=> mode == IDLE_LOW)
		else $error("receive kept without activate");
	a_rx_entry: assert property (
		mode == IDLE_LOW && power_up_bit && activate && primary_receive_select
		|=> mode == SETTLE_RX && synth_on)
		else $error("receive request not followed");
	a_rx_drop_full: assert property (
		mode == RX && rx_packet_end && rx_addr_match && rx_crc_ok &&
		rx_fifo_full |=> rx_drop && !rx_store)
		else $error("packet not dropped with full slots");
	a_one_packet: assert property (
		mode == TX && tx_packet_done && !activate && !ack_turn &&
		power_up_bit |=> mode == IDLE_LOW ##1 !tx_chain_on)
		else $error("pulse mode did not end in idle");
	a_empty_clk_idle: assert property (
		mode == TX && tx_packet_done && activate && tx_fifo_empty &&
		!ack_turn && power_up_bit |=> mode == IDLE_CLK)
		else $error("empty transmit queue missed clocks-on idle");
	a_upload_start: assert property (
		mode == IDLE_CLK && activate && tx_upload && power_up_bit
		|=> mode == SETTLE_TX)
		else $error("upload did not start the synthesizer");
	c_receive: cover property (mode == SETTLE_RX ##1 mode == RX);
	c_transmit: cover property (tx_start ##[1:20] mode == TX);
	c_clk_idle: cover property (mode == TX ##1 mode == IDLE_CLK);
	c_abort: cover property (tx_abort);

endmodule : radio_mode_controller

// ---- rtl/radio_mode_regs.svh ----
`ifndef RADIO_MODE_REGS_SVH
`define RADIO_MODE_REGS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define CORE_CLK_PERIOD_NS 40

// ----------------------------------------
// Mode timing (times as printed, counts derived)
// ----------------------------------------
`define WAKE_TIME_US 150
`define WAKE_CYCLES ((`WAKE_TIME_US * 1000) / `CORE_CLK_PERIOD_NS)
`define SETTLE_TIME_US 130
`define SETTLE_CYCLES ((`SETTLE_TIME_US * 1000) / `CORE_CLK_PERIOD_NS)
`define ACT_PULSE_TIME_US 10
`define ACT_PULSE_CYCLES \
	((`ACT_PULSE_TIME_US * 1000 + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define RPD_TIME_US 40
`define RPD_CYCLES \
	((`RPD_TIME_US * 1000 + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define TX_MAX_TIME_US 4000
`define TX_MAX_CYCLES ((`TX_MAX_TIME_US * 1000) / `CORE_CLK_PERIOD_NS)

// ----------------------------------------
// Air rate select codes and one-hot rate output
// ----------------------------------------
`define RATE_SEL_1M 2'h0
`define RATE_SEL_2M 2'h1
`define RATE_SEL_250K 2'h2
`define RATE_BIT_250K 0
`define RATE_BIT_1M 1
`define RATE_BIT_2M 2
`define RATE_RESET 3'h2

`endif

// ---- rtl/radio_mode_pkg.sv ----
package radio_mode_pkg;

	// ----------------------------------------
	// Operating modes, one-hot
	// ----------------------------------------
	typedef enum logic [7:0] {
		POWER_DOWN = 8'h01,
		WAKE = 8'h02,
		IDLE_LOW = 8'h04,
		IDLE_CLK = 8'h08,
		SETTLE_RX = 8'h10,
		SETTLE_TX = 8'h20,
		RX = 8'h40,
		TX = 8'h80
	} mode_e;

	typedef logic [2:0] rate_t;

endpackage : radio_mode_pkg

// ---- rtl/mode_timer.sv ----
`timescale 1ns/100ps

module mode_timer #(
	parameter int WIDTH = 12
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [WIDTH-1:0] value,
	output logic expired
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_expired;

	// Expires value+1 cycles after the load cycle
	always_comb begin
		if (load) begin
			next_count = value;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end else begin
			next_count = count;
		end
		next_expired = (next_count == '0);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count <= '0;
			expired <= 1'b1;
		end else begin
			count <= next_count;
			expired <= next_expired;
		end
	end

endmodule : mode_timer

// ---- rtl/rpd_filter.sv ----
`timescale 1ns/100ps

module rpd_filter #(
	parameter int HOLD = 1000,
	parameter int WIDTH = 10
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic raw,
	output logic flag
);

	localparam logic [WIDTH-1:0] LAST = WIDTH'(HOLD - 1);

	logic [WIDTH-1:0] run;
	logic [WIDTH-1:0] next_run;
	logic next_flag;

	// Outside receive the flag keeps its last value as a snapshot
	always_comb begin
		next_run = '0;
		next_flag = flag;
		if (enable && raw) begin
			next_run = (run == LAST) ? run : run + 1'b1;
		end
		if (enable) begin
			next_flag = raw && (run == LAST);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			run <= '0;
			flag <= 1'b0;
		end else begin
			run <= next_run;
			flag <= next_flag;
		end
	end

	a_rpd_min_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(flag) |-> $past(run) == LAST && $past(raw))
		else $error("power flag rose before the hold time");

endmodule : rpd_filter

// ---- test/packet_engine_model.sv ----
`timescale 1ns/100ps

// --------
// Transmit FIFO occupancy and packet engine stand-in
// --------
module packet_engine_model #(
	parameter int FAST = 20,
	parameter int SLOW = 400
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic tx_upload,
	input wire logic tx_start,
	input wire logic tx_chain_on,
	output logic tx_fifo_empty,
	output logic tx_packet_done
);
	int level;
	int left;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			level <= 0;
			left <= 0;
			tx_packet_done <= 1'b0;
		end else begin
			tx_packet_done <= 1'b0;
			// A start with an empty queue takes no packet
			level <= level + int'(tx_upload) - int'(tx_start && level > 0);
			// Prompt answers keep each transmit stay short while slow is low
			if (tx_start)
				left <= slow ? SLOW : FAST;
			else if (!tx_chain_on)
				left <= 0;
			else if (left == 1) begin
				tx_packet_done <= 1'b1;
				left <= 0;
			end else if (left > 1)
				left <= left - 1;
		end
	end

	assign tx_fifo_empty = (level == 0);
endmodule : packet_engine_model

// ---- test/radio_mode_controller_tb.sv ----
`timescale 1ns/100ps
`include "radio_mode_regs.svh"

module radio_mode_controller_tb
	import radio_mode_pkg::*;
;
	localparam int CAP = 200;
	localparam int FAST = 20;
	localparam int LIMIT = 50000;

	logic core_clk, sys_rst, power_up_bit, primary_receive_select, activate;
	logic select_n, tx_fifo_empty, tx_upload, auto_protocol_en, ack_send_req;
	logic tx_packet_done, rx_packet_end, rx_addr_match, rx_crc_ok, slow, v;
	logic rx_fifo_full, rx_signal_strong, osc_on, clock_buffers_on, synth_on;
	logic rx_chain_on, tx_chain_on, tx_start, tx_abort, rx_store, rx_drop;
	logic received_power_flag, regs_accessible;
	logic [1:0] air_rate_select, c;
	logic [31:0] rnd;
	mode_e mode;
	rate_t air_rate, exp_rate;
	int bad_count, n_tests, cycles, starts, n, i;

	radio_mode_controller #(.TX_MAX_CYCLES(CAP)) i_dut (.core_clk, .sys_rst,
		.power_up_bit, .primary_receive_select, .activate, .select_n,
		.tx_fifo_empty, .tx_upload, .auto_protocol_en, .ack_send_req,
		.tx_packet_done, .rx_packet_end, .rx_addr_match, .rx_crc_ok,
		.rx_fifo_full, .rx_signal_strong, .air_rate_select, .mode, .osc_on,
		.clock_buffers_on, .synth_on, .rx_chain_on, .tx_chain_on, .tx_start,
		.tx_abort, .rx_store, .rx_drop, .received_power_flag, .air_rate,
		.regs_accessible);

	packet_engine_model #(.FAST(FAST)) i_engine (.core_clk, .sys_rst, .slow,
		.tx_upload, .tx_start, .tx_chain_on, .tx_fifo_empty, .tx_packet_done);

	// --------
	// Helpers
	// --------
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next

	function automatic rate_t rate_exp(input logic [1:0] s, input rate_t p);
		case (s)
			`RATE_SEL_1M: return rate_t'(1 << `RATE_BIT_1M);
			`RATE_SEL_2M: return rate_t'(1 << `RATE_BIT_2M);
			`RATE_SEL_250K: return rate_t'(1 << `RATE_BIT_250K);
			default: return p;
		endcase
	endfunction : rate_exp

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wait_mode(input mode_e m, input int lim);
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			#1;
			k++;
		end while (mode !== m && k < lim + 4);
		check(mode, m);
		check(k <= lim, 1'b1);
	endtask : wait_mode

	task test_done;
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (tx_start === 1'b1)
			starts++;
		if (cycles == LIMIT) begin
			bad_count++;
			test_done();
		end
	end

	// --------
	// Main sequence
	// --------
	initial begin
		{power_up_bit, primary_receive_select, activate, tx_upload} = '0;
		{auto_protocol_en, ack_send_req, rx_packet_end, rx_addr_match} = '0;
		{rx_crc_ok, rx_fifo_full, rx_signal_strong, slow} = '0;
		air_rate_select = 2'h0;
		select_n = 1'b1;
		sys_rst = 1'b1;
		rnd = 32'h619739b5;
		exp_rate = `RATE_RESET;
		repeat (2) @(posedge core_clk);
		#1;
		check(mode, POWER_DOWN);
		check(air_rate, exp_rate);
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		power_up_bit <= 1'b1;
		wait_mode(WAKE, 1);
		wait_mode(IDLE_LOW, `WAKE_CYCLES);
		check(regs_accessible, 1'b1);
		check(osc_on, 1'b1);
		for (i = 0; i < 8; i++) begin
			rnd = lfsr_next(rnd);
			c = (i < 4) ? i[1:0] : rnd[1:0];
			@(posedge core_clk);
			air_rate_select <= c;
			exp_rate = rate_exp(c, exp_rate);
			@(posedge core_clk);
			#1;
			check(air_rate, exp_rate);
		end
		@(posedge core_clk);
		primary_receive_select <= 1'b1;
		activate <= 1'b1;
		wait_mode(RX, `SETTLE_CYCLES + 1);
		check(rx_chain_on, 1'b1);
		@(posedge core_clk);
		rx_signal_strong <= 1'b1;
		repeat (999) @(posedge core_clk);
		rx_signal_strong <= 1'b0;
		@(posedge core_clk);
		#1;
		check(received_power_flag, 1'b0);
		@(posedge core_clk);
		rx_signal_strong <= 1'b1;
		repeat (1000) @(posedge core_clk);
		#1;
		check(received_power_flag, 1'b1);
		for (i = 0; i < 10; i++) begin
			rnd = lfsr_next(rnd);
			@(posedge core_clk);
			rx_signal_strong <= 1'b0;
			rx_packet_end <= 1'b1;
			rx_addr_match <= rnd[0] | rnd[3];
			rx_crc_ok <= rnd[1] | rnd[4];
			rx_fifo_full <= rnd[2];
			@(posedge core_clk);
			rx_packet_end <= 1'b0;
			#1;
			v = (rnd[0] | rnd[3]) & (rnd[1] | rnd[4]);
			check(rx_store, v & !rnd[2]);
			check(rx_drop, v & rnd[2]);
		end
		check(mode, RX);
		@(posedge core_clk);
		activate <= 1'b0;
		wait_mode(IDLE_LOW, 1);
		@(posedge core_clk);
		primary_receive_select <= 1'b0;
		tx_upload <= 1'b1;
		activate <= 1'b1;
		@(posedge core_clk);
		tx_upload <= 1'b0;
		repeat (248) @(posedge core_clk);
		activate <= 1'b0;
		repeat (260) @(posedge core_clk);
		#1;
		check(mode, IDLE_LOW);
		@(posedge core_clk);
		activate <= 1'b1;
		repeat (250) @(posedge core_clk);
		activate <= 1'b0;
		wait_mode(TX, `SETTLE_CYCLES);
		check(tx_start, 1'b1);
		wait_mode(IDLE_LOW, FAST + 4);
		check(starts, 1);
		@(posedge core_clk);
		tx_upload <= 1'b1;
		activate <= 1'b1;
		repeat (2) @(posedge core_clk);
		tx_upload <= 1'b0;
		wait_mode(TX, 250 + `SETTLE_CYCLES);
		wait_mode(IDLE_CLK, 3 * FAST);
		check(starts, 3);
		check(clock_buffers_on, 1'b1);
		repeat (100) @(posedge core_clk);
		select_n <= 1'b0;
		@(posedge core_clk);
		tx_upload <= 1'b1;
		@(posedge core_clk);
		tx_upload <= 1'b0;
		wait_mode(SETTLE_TX, 1);
		check(synth_on, 1'b1);
		repeat (`SETTLE_CYCLES + 100) @(posedge core_clk);
		#1;
		check(mode, SETTLE_TX);
		@(posedge core_clk);
		select_n <= 1'b1;
		wait_mode(TX, 1);
		wait_mode(IDLE_CLK, FAST + 4);
		@(posedge core_clk);
		auto_protocol_en <= 1'b1;
		slow <= 1'b1;
		tx_upload <= 1'b1;
		@(posedge core_clk);
		tx_upload <= 1'b0;
		wait_mode(TX, `SETTLE_CYCLES + 1);
		n = 0;
		while (tx_abort !== 1'b1 && n < CAP + 9) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check(n <= CAP + 1, 1'b1);
		wait_mode(IDLE_CLK, 1);
		@(posedge core_clk);
		activate <= 1'b0;
		primary_receive_select <= 1'b1;
		slow <= 1'b0;
		wait_mode(IDLE_LOW, 1);
		@(posedge core_clk);
		activate <= 1'b1;
		wait_mode(RX, `SETTLE_CYCLES + 1);
		@(posedge core_clk);
		ack_send_req <= 1'b1;
		@(posedge core_clk);
		ack_send_req <= 1'b0;
		wait_mode(SETTLE_TX, 1);
		wait_mode(TX, `SETTLE_CYCLES);
		wait_mode(RX, FAST + `SETTLE_CYCLES + 4);
		@(posedge core_clk);
		primary_receive_select <= 1'b0;
		tx_upload <= 1'b1;
		@(posedge core_clk);
		tx_upload <= 1'b0;
		wait_mode(TX, `SETTLE_CYCLES + 1);
		wait_mode(IDLE_CLK, FAST + 4);
		@(posedge core_clk);
		tx_upload <= 1'b1;
		@(posedge core_clk);
		tx_upload <= 1'b0;
		wait_mode(TX, `SETTLE_CYCLES + 1);
		@(posedge core_clk);
		power_up_bit <= 1'b0;
		wait_mode(POWER_DOWN, 1);
		check({osc_on, synth_on, tx_chain_on}, 3'h0);
		check(regs_accessible, 1'b1);
		check(air_rate, exp_rate);
		test_done();
	end
endmodule : radio_mode_controller_tb
